// file: shared/card_pkg.sv
package card_pkg;

    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_STATUS = 16'hfe08;
    localparam logic [15:0] IDX_RXDATA = 16'hfe09;
    localparam logic [15:0] IDX_LINE = 16'hfe0a;
    localparam logic [15:0] IDX_MODE = 16'hfe0d;

    // card_receive_status fields
    localparam int ST_NINTH = 7;
    localparam int ST_FINAL = 5;
    localparam int ST_CHECK = 4;
    localparam int ST_FULL = 3;
    localparam int ST_EMPTY = 2;
    localparam int ST_OVF = 1;
    localparam int ST_PAR = 0;
    localparam logic [7:0] ST_RESET = 8'h00;

    // card_receive_data
    localparam logic [7:0] RXDATA_RESET = 8'h00;

    // card_line_control fields
    localparam int LC_RST = 7;
    localparam int LC_IO = 5;
    localparam int LC_DIR = 4;
    localparam int LC_C8 = 3;
    localparam int LC_C4 = 2;
    localparam int LC_LVL = 1;
    localparam int LC_STOP = 0;
    localparam logic [7:0] LC_RESET = 8'h21;
    localparam logic LC_DIR_RESET = 1'b1;

    // protocol_mode_reg fields
    localparam int MD_MODE = 0;
    localparam int MD_NINE = 2;
    localparam int MD_CRC = 3;
    localparam logic [7:0] MD_RESET = 8'h00;

    typedef enum logic [1:0] {
        MODE_ASYNC = 2'b00,
        MODE_SYNC = 2'b01,
        MODE_BYPASS = 2'b10,
        MODE_AUTO = 2'b11
    } card_mode_e;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b10,
        RX_PARITY = 2'b11
    } rx_state_e;

    // block check
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_RESIDUE = 16'h1d0f;
    localparam logic [7:0] LRC_RESIDUE = 8'h00;

    // card clocks per elementary time unit
    localparam int ETU_CLKS = 372;
    localparam int RX_FIFO_DEPTH = 4;

endpackage : card_pkg

// file: shared/rx_fifo_if.sv
`timescale 1ns/1ps
interface rx_fifo_if #(parameter int W = 8);
    logic push;
    logic [W-1:0] wdata;
    logic pop;
    logic [W-1:0] rdata;
    logic full;
    logic empty;
    modport user(output push, output wdata, output pop, input rdata, input full, input empty);
    modport store(input push, input wdata, input pop, output rdata, output full, output empty);
endinterface : rx_fifo_if

// file: logic/card_rx_fifo.sv
`timescale 1ns/1ps
module card_rx_fifo #(
    parameter int W = 8,
    parameter int DEPTH = card_pkg::RX_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // queue port
    rx_fifo_if.store fq
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic do_push;
    logic do_pop;

    assign do_push = fq.push && !fq.full;
    assign do_pop = fq.pop && !fq.empty;
    assign fq.full = (count_r == (AW+1)'(DEPTH));
    assign fq.empty = (count_r == '0);
    assign fq.rdata = mem[rd_ptr_r];

    // cleared so that a read of the empty queue after reset returns zero
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else if (do_push) begin
            mem[wr_ptr_r] <= fq.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule : card_rx_fifo

// file: logic/card_rx_line.sv
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
module card_rx_line #(
    parameter int ETU_CLKS = card_pkg::ETU_CLKS,
    parameter int FIFO_DEPTH = card_pkg::RX_FIFO_DEPTH
) (
    // system
    input wire logic CLK_SYS,
    input wire logic RST,
    // avalon-mm slave, byte address
    input wire logic [17:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [31:0] WRITEDATA,
    output logic [31:0] READDATA,
    output logic WAITREQUEST,
    // card clock source and contacts
    input wire logic CARD_CLK_SRC,
    output logic CARD_CLK,
    output logic CARD_RST,
    input wire logic CARD_IO_I,
    output logic CARD_IO_O,
    output logic CARD_IO_OE,
    // activation sequencer
    input wire logic SEQ_RST_HOLD,
    // events
    output logic RX_FAULT_EVENT
);
    localparam int CW = $clog2(ETU_CLKS + 1);
    localparam logic [CW-1:0] ETU_LAST = CW'(ETU_CLKS - 1);
    localparam logic [CW-1:0] ETU_MID = CW'(ETU_CLKS / 2 - 1);

    rx_fifo_if #(.W(8)) fq ();

    card_rx_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(CLK_SYS),
        .rst(RST),
        .fq(fq)
    );

    // input synchronisers
    logic clk_s1_r, clk_s2_r, clk_s3_r;
    logic io_s1_r, io_s2_r, io_s3_r;
    logic src_rise;
    logic io_fall;

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            clk_s1_r <= 1'b0;
            clk_s2_r <= 1'b0;
            clk_s3_r <= 1'b0;
            io_s1_r <= 1'b1;
            io_s2_r <= 1'b1;
            io_s3_r <= 1'b1;
        end else begin
            clk_s1_r <= CARD_CLK_SRC;
            clk_s2_r <= clk_s1_r;
            clk_s3_r <= clk_s2_r;
            io_s1_r <= CARD_IO_I;
            io_s2_r <= io_s1_r;
            io_s3_r <= io_s2_r;
        end
    end

    assign src_rise = clk_s2_r && !clk_s3_r;
    assign io_fall = !io_s2_r && io_s3_r;

    // registers
    logic [7:0] line_r;
    logic [7:0] mode_r;
    logic final_r;
    logic check_r;
    logic ovf_r;
    logic par_r;
    logic ninth_r;
    logic line_cap_r;
    card_pkg::card_mode_e mode;
    logic is_sync;
    logic is_bypass;
    logic clk_nxt;

    assign mode = card_pkg::card_mode_e'(mode_r[card_pkg::MD_MODE +: 2]);
    assign is_sync = (mode == card_pkg::MODE_SYNC);
    assign is_bypass = (mode == card_pkg::MODE_BYPASS);
    assign clk_nxt = (is_bypass || line_r[card_pkg::LC_STOP]) ? line_r[card_pkg::LC_LVL] : clk_s2_r;

    // bus slave: one wait cycle, answer on the second cycle
    logic ack_r;
    logic accept;
    logic [15:0] idx;
    logic snap_ovf_r;
    logic snap_par_r;
    logic [7:0] rd_val;
    logic line_read;

    assign idx = ADDRESS[17:2];
    assign WAITREQUEST = (READ || WRITE) && !ack_r;
    assign accept = (READ || WRITE) && ack_r;

    always_comb begin
        line_read = is_sync ? line_cap_r : CARD_IO_I;
        unique case (idx)
            card_pkg::IDX_STATUS: rd_val = {ninth_r, 1'b0, final_r, check_r,
                fq.full, fq.empty, ovf_r, par_r};
            card_pkg::IDX_RXDATA: rd_val = fq.rdata;
            card_pkg::IDX_LINE: rd_val = {line_r[7:6], line_read, line_r[4:0]};
            card_pkg::IDX_MODE: rd_val = mode_r;
            default: rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ack_r <= 1'b0;
            READDATA <= 32'h0000_0000;
            snap_ovf_r <= 1'b0;
            snap_par_r <= 1'b0;
        end else begin
            ack_r <= (READ || WRITE) && !ack_r;
            if (READ && !ack_r) begin
                READDATA <= {24'h000000, rd_val};
                snap_ovf_r <= (idx == card_pkg::IDX_STATUS) && ovf_r;
                snap_par_r <= (idx == card_pkg::IDX_STATUS) && par_r;
            end
        end
    end

    logic wr_status;
    logic rd_status;
    assign wr_status = accept && WRITE && (idx == card_pkg::IDX_STATUS);
    assign rd_status = accept && READ && (idx == card_pkg::IDX_STATUS);
    assign fq.pop = accept && READ && (idx == card_pkg::IDX_RXDATA) && !fq.empty;

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            line_r <= card_pkg::LC_RESET;
            line_r[card_pkg::LC_DIR] <= card_pkg::LC_DIR_RESET;
            mode_r <= card_pkg::MD_RESET;
            final_r <= card_pkg::ST_RESET[card_pkg::ST_FINAL];
        end else if (accept && WRITE) begin
            if (idx == card_pkg::IDX_LINE) begin
                line_r <= WRITEDATA[7:0];
            end
            if (idx == card_pkg::IDX_MODE) begin
                mode_r <= {4'h0, WRITEDATA[3:0]};
            end
            if (idx == card_pkg::IDX_STATUS) begin
                final_r <= WRITEDATA[card_pkg::ST_FINAL];
            end
        end
    end

    // async character receiver, counted in card clock source rising edges
    card_pkg::rx_state_e rx_st_r;
    logic [CW-1:0] etu_cnt_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic a_done;
    logic a_bad;
    logic etu_end;

    assign etu_end = src_rise && (etu_cnt_r == ETU_LAST);
    assign a_done = (rx_st_r == card_pkg::RX_PARITY) && etu_end;
    assign a_bad = ^{shift_r, io_s2_r};

    always_ff @(posedge CLK_SYS) begin
        if (RST || is_sync || is_bypass) begin
            rx_st_r <= card_pkg::RX_IDLE;
            etu_cnt_r <= '0;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
        end else begin
            if (src_rise) begin
                etu_cnt_r <= (etu_cnt_r == ETU_LAST) ? '0 : etu_cnt_r + 1'b1;
            end
            unique case (rx_st_r)
                card_pkg::RX_IDLE: begin
                    etu_cnt_r <= '0;
                    if (io_fall) begin
                        rx_st_r <= card_pkg::RX_START;
                    end
                end
                card_pkg::RX_START: begin
                    if (src_rise && etu_cnt_r == ETU_MID) begin
                        etu_cnt_r <= '0;
                        bit_cnt_r <= 4'h0;
                        rx_st_r <= io_s2_r ? card_pkg::RX_IDLE : card_pkg::RX_DATA;
                    end
                end
                card_pkg::RX_DATA: begin
                    if (etu_end) begin
                        shift_r <= {io_s2_r, shift_r[7:1]};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        if (bit_cnt_r == 4'h7) begin
                            rx_st_r <= card_pkg::RX_PARITY;
                        end
                    end
                end
                card_pkg::RX_PARITY: begin
                    if (etu_end) begin
                        rx_st_r <= card_pkg::RX_IDLE;
                    end
                end
            endcase
        end
    end

    // synchronous-mode bit capture on card-clock rise
    logic [3:0] s_cnt_r;
    logic [7:0] s_shift_r;
    logic s_edge;
    logic s_done;

    // count the rises the card really sees, including the one at a clock restart
    assign s_edge = is_sync && clk_nxt && !CARD_CLK;
    assign s_done = s_edge && (s_cnt_r == 4'h7);

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            s_cnt_r <= 4'h0;
            s_shift_r <= 8'h00;
            ninth_r <= 1'b0;
            line_cap_r <= 1'b0;
        end else if (!is_sync) begin
            s_cnt_r <= 4'h0;
        end else if (s_edge) begin
            line_cap_r <= io_s2_r;
            if (s_cnt_r < 4'h8) begin
                s_shift_r <= {io_s2_r, s_shift_r[7:1]};
            end
            if (s_cnt_r == 4'h8) begin
                ninth_r <= io_s2_r;
            end
            if ((s_cnt_r == 4'h7 && !mode_r[card_pkg::MD_NINE]) || s_cnt_r == 4'h8) begin
                s_cnt_r <= 4'h0;
            end else begin
                s_cnt_r <= s_cnt_r + 4'h1;
            end
        end
    end

    // completed byte from either path
    logic done;
    logic [7:0] done_byte;
    assign done = a_done || s_done;
    assign done_byte = s_done ? {io_s2_r, s_shift_r[7:1]} : shift_r;

    assign fq.push = done && !ovf_r && !fq.full;
    assign fq.wdata = done_byte;

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ovf_r <= 1'b0;
            par_r <= 1'b0;
        end else begin
            ovf_r <= (done && fq.full) || (ovf_r && !(rd_status && snap_ovf_r));
            par_r <= (a_done && a_bad) || (par_r && !(rd_status && snap_par_r));
        end
    end

    // block check accumulators
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = (r[15] ^ b[i]) ? ({r[14:0], 1'b0} ^ card_pkg::CRC_POLY) : {r[14:0], 1'b0};
        end
        return r;
    endfunction : crc_step

    logic [15:0] crc_r;
    logic [7:0] lrc_r;
    logic [15:0] crc_nxt;
    logic [7:0] lrc_nxt;
    logic mismatch;

    assign crc_nxt = crc_step(crc_r, done_byte);
    assign lrc_nxt = lrc_r ^ done_byte;
    assign mismatch = mode_r[card_pkg::MD_CRC] ? (crc_nxt != card_pkg::CRC_RESIDUE)
        : (lrc_nxt != card_pkg::LRC_RESIDUE);

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            crc_r <= card_pkg::CRC_INIT;
            lrc_r <= 8'h00;
            check_r <= 1'b0;
        end else begin
            if (done && final_r) begin
                crc_r <= card_pkg::CRC_INIT;
                lrc_r <= 8'h00;
            end else if (done) begin
                crc_r <= crc_nxt;
                lrc_r <= lrc_nxt;
            end
            check_r <= (done && final_r && mismatch) || (check_r && !wr_status);
        end
    end

    assign RX_FAULT_EVENT = ovf_r || par_r;

    // contact drivers
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            CARD_RST <= 1'b0;
            CARD_CLK <= 1'b0;
            CARD_IO_O <= 1'b1;
            CARD_IO_OE <= 1'b0;
        end else begin
            CARD_RST <= is_sync ? line_r[card_pkg::LC_RST]
                : !(line_r[card_pkg::LC_RST] || SEQ_RST_HOLD);
            CARD_CLK <= clk_nxt;
            CARD_IO_O <= line_r[card_pkg::LC_IO];
            CARD_IO_OE <= (is_bypass || is_sync) && !line_r[card_pkg::LC_DIR];
        end
    end
endmodule : card_rx_line

// file: sim/card_rx_line_monitor.sv
`timescale 1ns/1ps
module card_rx_line_monitor (
    // system
    input wire logic CLK_SYS,
    input wire logic RST,
    // register bus
    input wire logic [17:0] ADDRESS,
    input wire logic READ,
    input wire logic WRITE,
    input wire logic [31:0] WRITEDATA,
    input wire logic [31:0] READDATA,
    input wire logic WAITREQUEST,
    // card contacts and events
    input wire logic CARD_CLK,
    input wire logic CARD_RST,
    input wire logic CARD_IO_O,
    input wire logic CARD_IO_OE,
    input wire logic RX_FAULT_EVENT
);
    logic [7:0] lc_r;
    logic [7:0] md_r;
    logic acc;
    logic st_rd;
    logic oe_ok;
    assign acc = !WAITREQUEST && (READ || WRITE);
    assign st_rd = READ && acc && ADDRESS[17:2] == card_pkg::IDX_STATUS;
    assign oe_ok = (md_r[1:0] == 2'h1 || md_r[1:0] == 2'h2) && !lc_r[card_pkg::LC_DIR];
    // shadow of the control registers as software wrote them
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            lc_r <= card_pkg::LC_RESET;
            md_r <= card_pkg::MD_RESET;
        end else if (WRITE && acc && ADDRESS[17:2] == card_pkg::IDX_LINE) begin
            lc_r <= WRITEDATA[7:0];
        end else if (WRITE && acc && ADDRESS[17:2] == card_pkg::IDX_MODE) begin
            md_r <= WRITEDATA[7:0];
        end
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    one_wait_a: assert property ($rose(READ || WRITE) |-> WAITREQUEST ##1 !WAITREQUEST)
        else $error("bus answer not after one wait cycle");
    idle_nowait_a: assert property (!(READ || WRITE) |-> !WAITREQUEST)
        else $error("wait raised without request");
    rd_upper_a: assert property (READDATA[31:8] == 24'h0)
        else $error("read data upper bits set");
    fault_hold_a: assert property (st_rd && READDATA[1:0] != 2'h0 |-> RX_FAULT_EVENT)
        else $error("fault event low while flag set");
    fault_clear_a: assert property ($fell(RX_FAULT_EVENT) |-> $past(st_rd))
        else $error("fault event fell without status read");
    rst_invert_a: assert property ($rose(lc_r[7]) && md_r[1:0] != 2'h1 |-> ##[0:3] !CARD_RST)
        else $error("card reset not driven low");
    rst_direct_a: assert property ($rose(lc_r[7]) && md_r[1:0] == 2'h1 |-> ##[0:3] CARD_RST)
        else $error("card reset not driven high in sync mode");
    oe_dir_a: assert property (CARD_IO_OE |-> oe_ok || $past(oe_ok) || $past(oe_ok, 2))
        else $error("line driven while direction is input");
    byp_clk_a: assert property ((md_r[1:0] == 2'h2 && $stable(lc_r) && $stable(md_r)) [*3]
        |-> CARD_CLK == lc_r[card_pkg::LC_LVL]) else $error("bypass clock not at level bit");
    halt_clk_a: assert property ((md_r[1:0] != 2'h2 && lc_r[0] && $stable(lc_r) && $stable(md_r)) [*4]
        |-> CARD_CLK == lc_r[card_pkg::LC_LVL]) else $error("halted clock not at level bit");
    byp_io_a: assert property ((CARD_IO_OE && md_r[1:0] == 2'h2 && $stable(lc_r)) [*3]
        |-> CARD_IO_O == lc_r[card_pkg::LC_IO]) else $error("bypass line not at written bit");
endmodule : card_rx_line_monitor

bind card_rx_line card_rx_line_monitor u_card_rx_line_monitor (.CLK_SYS(CLK_SYS), .RST(RST),
    .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA), .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST), .CARD_CLK(CARD_CLK), .CARD_RST(CARD_RST), .CARD_IO_O(CARD_IO_O),
    .CARD_IO_OE(CARD_IO_OE), .RX_FAULT_EVENT(RX_FAULT_EVENT));

// file: sim/card_model.sv
`timescale 1ns/1ps
module card_model #(
    parameter int ETU = 8
) (
    // card contacts
    input wire logic clk,
    output logic io_o,
    output logic io_oe
);
    initial begin
        io_o = 1'b1;
        io_oe = 1'b0;
    end
    // start, eight data bits lsb first, even parity, then guard time
    task automatic send_async(input logic [7:0] b, input logic bad);
        logic [9:0] f;
        f = {(^b) ^ bad, b, 1'b0};
        io_oe = 1'b1;
        for (int i = 0; i < 10; i++) begin
            io_o = f[i];
            repeat (ETU) @(posedge clk);
        end
        io_oe = 1'b0;
        repeat (2 * ETU) @(posedge clk);
    endtask : send_async
    // one bit per card clock rise, changed on the falling edge
    task automatic send_sync(input logic [8:0] d);
        io_oe = 1'b1;
        for (int i = 0; i < 9; i++) begin
            io_o = d[i];
            @(posedge clk);
            if (i < 8) begin
                @(negedge clk);
            end
        end
        #10;
        io_o = ~d[8];
    endtask : send_sync
    task automatic release_line();
        io_oe = 1'b0;
    endtask : release_line
endmodule : card_model

// file: sim/test_card_rx_line.sv
`timescale 1ns/1ps
module test_card_rx_line;
    localparam int ETU = 8;
    localparam logic [15:0] ST = card_pkg::IDX_STATUS;
    localparam logic [15:0] DT = card_pkg::IDX_RXDATA;
    localparam logic [15:0] LN = card_pkg::IDX_LINE;
    localparam logic [15:0] MD = card_pkg::IDX_MODE;
    logic CLK_SYS = 1'b0;
    logic RST = 1'b1;
    logic [17:0] ADDRESS = 18'h0;
    logic READ = 1'b0;
    logic WRITE = 1'b0;
    logic [31:0] WRITEDATA = 32'h0;
    logic [31:0] READDATA;
    logic WAITREQUEST;
    logic CARD_CLK_SRC = 1'b0;
    logic CARD_CLK;
    logic CARD_RST;
    logic CARD_IO_O;
    logic CARD_IO_OE;
    logic SEQ_RST_HOLD = 1'b0;
    logic RX_FAULT_EVENT;
    logic card_o;
    logic card_oe;
    logic io_line;
    logic [7:0] rxb [4] = '{8'h3c, 8'ha5, 8'h01, 8'hff};
    int err_count = 0;
    int cmp_count = 0;
    always #2.5 CLK_SYS = ~CLK_SYS;
    initial begin
        #7;
        forever #32 CARD_CLK_SRC = ~CARD_CLK_SRC;
    end
    // pulled-up line shared by block and card
    assign io_line = CARD_IO_OE ? CARD_IO_O : (card_oe ? card_o : 1'b1);
    card_rx_line #(.ETU_CLKS(ETU), .FIFO_DEPTH(4)) u_card_rx_line (.CLK_SYS(CLK_SYS), .RST(RST),
        .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA), .READDATA(READDATA),
        .WAITREQUEST(WAITREQUEST), .CARD_CLK_SRC(CARD_CLK_SRC), .CARD_CLK(CARD_CLK), .CARD_RST(CARD_RST),
        .CARD_IO_I(io_line), .CARD_IO_O(CARD_IO_O), .CARD_IO_OE(CARD_IO_OE), .SEQ_RST_HOLD(SEQ_RST_HOLD),
        .RX_FAULT_EVENT(RX_FAULT_EVENT));
    card_model #(.ETU(ETU)) u_card_model (.clk(CARD_CLK), .io_o(card_o), .io_oe(card_oe));
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd, output logic [7:0] rd);
        @(posedge CLK_SYS);
        ADDRESS <= {idx, 2'b00};
        WRITEDATA <= {24'h0, wd};
        READ <= !wr;
        WRITE <= wr;
        @(posedge CLK_SYS);
        while (WAITREQUEST !== 1'b0) begin
            @(posedge CLK_SYS);
        end
        rd = READDATA[7:0];
        chk("read data upper", READDATA[31:24], 8'h00);
        READ <= 1'b0;
        WRITE <= 1'b0;
    endtask : bus
    task automatic rd_chk(input logic [15:0] idx, input logic [7:0] exp, input logic [7:0] mask);
        logic [7:0] v;
        bus(1'b0, idx, 8'h0, v);
        chk($sformatf("register %h", idx), v & mask, exp);
    endtask : rd_chk
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [7:0] v;
        bus(1'b1, idx, d, v);
    endtask : wr
    task automatic wrs(input logic [15:0] idx, input logic [7:0] d);
        wr(idx, d);
        repeat (4) @(negedge CLK_SYS);
    endtask : wrs
    task automatic tally_and_finish();
        if (err_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (60000) @(posedge CLK_SYS);
        chk("watchdog", 8'h1, 8'h0);
        tally_and_finish();
    end
    initial begin
        repeat (5) @(posedge CLK_SYS);
        RST <= 1'b0;
        rd_chk(ST, 8'h04, 8'hff);
        chk("fault event", {7'h0, RX_FAULT_EVENT}, 8'h00);
        rd_chk(LN, 8'h31, 8'hff);
        rd_chk(DT, 8'h00, 8'hff);
        rd_chk(16'h0001, 8'h00, 8'hff);
        chk("card reset", {7'h0, CARD_RST}, 8'h01);
        wrs(LN, 8'hb1);
        chk("card reset", {7'h0, CARD_RST}, 8'h00);
        wrs(MD, 8'h03);
        chk("card reset", {7'h0, CARD_RST}, 8'h00);
        wrs(LN, 8'h31);
        @(posedge CLK_SYS) SEQ_RST_HOLD <= 1'b1;
        repeat (4) @(negedge CLK_SYS);
        chk("card reset", {7'h0, CARD_RST}, 8'h00);
        @(posedge CLK_SYS) SEQ_RST_HOLD <= 1'b0;
        repeat (4) @(negedge CLK_SYS);
        chk("card reset", {7'h0, CARD_RST}, 8'h01);
        wr(MD, 8'h00);
        wr(LN, 8'h30);
        foreach (rxb[i]) u_card_model.send_async(rxb[i], 1'b0);
        rd_chk(ST, 8'h08, 8'hff);
        u_card_model.send_async(8'h77, 1'b0);
        chk("fault event", {7'h0, RX_FAULT_EVENT}, 8'h01);
        rd_chk(DT, rxb[0], 8'hff);
        u_card_model.send_async(8'h66, 1'b0);
        rd_chk(ST, 8'h02, 8'hff);
        rd_chk(ST, 8'h00, 8'hff);
        chk("fault event", {7'h0, RX_FAULT_EVENT}, 8'h00);
        for (int i = 1; i < 4; i++) rd_chk(DT, rxb[i], 8'hff);
        rd_chk(ST, 8'h04, 8'hff);
        u_card_model.send_async(8'h55, 1'b1);
        chk("fault event", {7'h0, RX_FAULT_EVENT}, 8'h01);
        rd_chk(ST, 8'h01, 8'h01);
        rd_chk(ST, 8'h00, 8'h01);
        rd_chk(DT, 8'h55, 8'hff);
        wr(ST, 8'h20);
        u_card_model.send_async(8'h5a, 1'b0);
        wr(ST, 8'h20);
        u_card_model.send_async(8'h00, 1'b0);
        rd_chk(ST, 8'h20, 8'h30);
        u_card_model.send_async(8'h11, 1'b0);
        rd_chk(ST, 8'h30, 8'h30);
        wr(ST, 8'h00);
        rd_chk(ST, 8'h00, 8'h30);
        rd_chk(DT, 8'h5a, 8'hff);
        rd_chk(DT, 8'h00, 8'hff);
        rd_chk(DT, 8'h11, 8'hff);
        wr(MD, 8'h08);
        wr(ST, 8'h20);
        u_card_model.send_async(8'h00, 1'b0);
        rd_chk(ST, 8'h30, 8'h30);
        wr(ST, 8'h00);
        rd_chk(DT, 8'h00, 8'hff);
        wr(LN, 8'h31);
        wrs(MD, 8'h05);
        chk("card reset", {7'h0, CARD_RST}, 8'h00);
        wrs(LN, 8'hb1);
        chk("card reset", {7'h0, CARD_RST}, 8'h01);
        fork
            u_card_model.send_sync(9'h1a5);
            wr(LN, 8'hb0);
        join
        wr(LN, 8'hb1);
        rd_chk(ST, 8'h80, 8'h84);
        rd_chk(LN, 8'h20, 8'h20);
        rd_chk(DT, 8'ha5, 8'hff);
        u_card_model.release_line();
        wrs(MD, 8'h02);
        wrs(LN, 8'h22);
        chk("line enable", {7'h0, CARD_IO_OE}, 8'h01);
        chk("line out", {7'h0, CARD_IO_O}, 8'h01);
        chk("card clock", {7'h0, CARD_CLK}, 8'h01);
        chk("card reset", {7'h0, CARD_RST}, 8'h01);
        wrs(LN, 8'h01);
        chk("line out", {7'h0, CARD_IO_O}, 8'h00);
        chk("card clock", {7'h0, CARD_CLK}, 8'h00);
        rd_chk(LN, 8'h00, 8'h20);
        tally_and_finish();
    end
endmodule : test_card_rx_line
